//--- core/smbus_word_register_slave.sv
// Serial word-register slave: bus engine on the link clock, register file on clk
`timescale 1ns/1ps
// Summary of operation
// - SDA changes only while SCL low
// - Nine pulses per byte, ninth is acknowledge
// - Direction 0 writes, 1 reads
// - Acknowledge own address, else leave SDA high
// - Acknowledge every register address byte
// - Eight bits, MSB first, then acknowledge
// - Word travels low byte then high byte
// - Serve 16-bit word transfers
// - No acknowledge unless a rail above threshold
// - Slave only, Read-word and Write-word only
// - Address is 10010, pin b, pin a
// - Select pins latched once at reset
// - Commands accepted only after reset completes
// - Current caps keep 11 bits at [12:2]
// - Target voltage keeps 12 bits at [14:3]
// - Source alarm keeps 6 bits at [12:7]
// - Load alarm keeps 6 bits at [13:8]
// - Store valid bits only, clamp to maximum
module smbus_word_register_slave
  import smbus_word_pkg::*;
#(
  parameter logic [15:0] SRC_CAP_RST = 16'h05DC
) (
  // System clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link clock for the bus engine
  input wire logic link_clk,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Straps and rail comparators
  input wire logic slave_sel_pin_a,
  input wire logic slave_sel_pin_b,
  input wire logic [2:0] program_strap_pin,
  input wire logic source_port_voltage,
  input wire logic output_rail_voltage,
  // Regulator side
  input wire logic [15:0] status_word_a,
  output regs_s regs
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] cap_store(input logic [15:0] w);
    logic [10:0] f;
    f = w[CAP_LSB +: CAP_W];
    if (f > CAP_MAX) begin
      f = CAP_MAX;
    end
    cap_store = 16'h0000;
    cap_store[CAP_LSB +: CAP_W] = f;
  endfunction : cap_store

  function automatic logic [15:0] keep_field(input logic [15:0] w, input int lsb, input int width);
    logic [15:0] m;
    m = 16'((17'h00001 << width) - 17'h00001) << lsb;
    keep_field = w & m;
  endfunction : keep_field

  function automatic logic [15:0] volt_default(input logic [2:0] code);
    logic [11:0] c;
    case (code)
      3'h1: c = VOLT_CODE_1;
      3'h2: c = VOLT_CODE_2;
      3'h3: c = VOLT_CODE_3;
      3'h4: c = VOLT_CODE_4;
      default: c = VOLT_CODE_0;
    endcase
    volt_default = 16'h0000;
    volt_default[VOLT_LSB +: VOLT_W] = c;
  endfunction : volt_default

  // ****************************************
  // Link domain: reset and pin synchronisers
  // ****************************************
  logic link_rst_m;
  logic link_rst;
  logic [4:0] pin_m;
  logic [4:0] pin_s;
  logic scl_q;
  logic sda_q;

  always_ff @(posedge link_clk) begin
    link_rst_m <= reset;
    link_rst <= link_rst_m;
  end

  always_ff @(posedge link_clk) begin
    pin_m <= {output_rail_voltage, source_port_voltage, slave_sel_pin_b, slave_sel_pin_a, sda_i};
    pin_s <= pin_m;
  end

  logic scl_m;
  logic scl_r;
  always_ff @(posedge link_clk) begin
    scl_m <= scl_i;
    scl_r <= scl_m;
    scl_q <= scl_r;
    sda_q <= pin_s[0];
  end

  wire sda_now = pin_s[0];
  wire scl_hi = scl_r & scl_q;
  wire scl_rise = scl_r & ~scl_q;
  wire scl_fall = ~scl_r & scl_q;
  wire start_seen = scl_hi & sda_q & ~sda_now;
  wire stop_seen = scl_hi & ~sda_q & sda_now;
  wire rail_ok = pin_s[3] | pin_s[4];

  // Select pins are caught while the link reset holds, then frozen
  logic [1:0] addr_sel;
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      addr_sel <= {pin_s[2], pin_s[1]};
    end
  end

  wire [6:0] own_addr = {SLAVE_ADDR_FIXED, addr_sel};

  // ****************************************
  // Link domain: byte engine
  // ****************************************
  typedef enum {st_idle, st_rx, st_ack, st_tx, st_mack, st_wait} link_state_e;
  typedef enum {ph_ctrl, ph_reg, ph_lo, ph_hi, ph_done} phase_e;

  link_state_e state;
  phase_e phase;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic reading;
  logic tx_high;
  logic host_ack;
  logic [7:0] wr_lo;
  wr_req_s wr_req;
  logic [7:0] rd_index;
  logic wr_tgl;
  logic rd_req_tgl;
  logic [15:0] rd_word_link;

  wire byte_done = (state == st_rx) & scl_fall & (bit_cnt == BYTE_BITS);
  wire ctrl_match = (rx_shift[7:1] == own_addr) & rail_ok;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state <= st_idle;
      phase <= ph_ctrl;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'hFF;
      reading <= 1'b0;
      tx_high <= 1'b0;
      host_ack <= 1'b0;
      wr_lo <= 8'h00;
      wr_req <= '0;
      rd_index <= 8'h00;
      wr_tgl <= 1'b0;
      rd_req_tgl <= 1'b0;
    end else if (start_seen) begin
      // A repeated START restarts framing but keeps the register index
      state <= st_rx;
      phase <= ph_ctrl;
      bit_cnt <= 4'h0;
    end else if (stop_seen) begin
      state <= st_idle;
    end else begin
      case (state)
        st_rx: begin
          if (scl_rise) begin
            rx_shift <= {rx_shift[6:0], sda_now};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (byte_done) begin
            bit_cnt <= 4'h0;
            state <= st_ack;
            case (phase)
              ph_ctrl: begin
                if (ctrl_match) begin
                  reading <= (rx_shift[0] == DIR_READ);
                  phase <= ph_reg;
                end else begin
                  state <= st_wait;
                end
              end
              ph_reg: begin
                rd_index <= rx_shift;
                rd_req_tgl <= ~rd_req_tgl;
                phase <= ph_lo;
              end
              ph_lo: begin
                wr_lo <= rx_shift;
                phase <= ph_hi;
              end
              ph_hi: begin
                wr_req <= '{index: rd_index, word: {rx_shift, wr_lo}};
                wr_tgl <= ~wr_tgl;
                phase <= ph_done;
              end
              default: begin
                state <= st_wait;
              end
            endcase
          end
        end
        st_ack: begin
          if (scl_fall) begin
            if (reading) begin
              state <= st_tx;
              tx_shift <= rd_word_link[7:0];
              tx_high <= 1'b0;
            end else begin
              state <= st_rx;
            end
          end
        end
        st_tx: begin
          if (scl_fall) begin
            tx_shift <= {tx_shift[6:0], 1'b1};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == BYTE_BITS - 4'h1) begin
              bit_cnt <= 4'h0;
              state <= st_mack;
            end
          end
        end
        st_mack: begin
          if (scl_rise) begin
            host_ack <= ~sda_now;
          end
          if (scl_fall) begin
            if (host_ack & ~tx_high) begin
              state <= st_tx;
              tx_shift <= rd_word_link[15:8];
              tx_high <= 1'b1;
            end else begin
              state <= st_wait;
            end
          end
        end
        st_wait: begin
          state <= st_wait;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // Open-drain drive, updated one link cycle after scl_fall is seen
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= (state == st_ack) | ((state == st_tx) & ~tx_shift[7]);
    end
  end

  assign sda_o = 1'b0;

  // ****************************************
  // Crossing: read word back to the link
  // ****************************************
  logic rd_ack_tgl;
  logic [15:0] rd_word;
  logic [2:0] rd_ack_sync;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      rd_ack_sync <= 3'h0;
      rd_word_link <= 16'h0000;
    end else begin
      rd_ack_sync <= {rd_ack_sync[1:0], rd_ack_tgl};
      if (rd_ack_sync[2] != rd_ack_sync[1]) begin
        rd_word_link <= rd_word;
      end
    end
  end

  // ****************************************
  // System domain: event synchronisers
  // ****************************************
  logic [2:0] wr_sync;
  logic [2:0] rd_sync;
  logic [2:0] program_strap_pin_m;
  logic [2:0] program_strap_pin_s;

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_sync <= 3'h0;
      rd_sync <= 3'h0;
    end else begin
      wr_sync <= {wr_sync[1:0], wr_tgl};
      rd_sync <= {rd_sync[1:0], rd_req_tgl};
    end
  end

  always_ff @(posedge clk) begin
    program_strap_pin_m <= program_strap_pin;
    program_strap_pin_s <= program_strap_pin_m;
  end

  wire wr_evt = wr_sync[2] != wr_sync[1];
  wire rd_evt = rd_sync[2] != rd_sync[1];

  // ****************************************
  // System domain: register file
  // ****************************************
  // Index and word are held stable in the link domain well before the toggle lands
  always_ff @(posedge clk) begin
    if (reset) begin
      regs.out_cap <= OUT_CAP_RST;
      regs.fwd_volt <= volt_default(program_strap_pin_s);
      regs.cfg_a <= CFG_RST;
      regs.cfg_b <= CFG_RST;
      regs.cfg_c <= CFG_RST;
      regs.src_cap <= cap_store(SRC_CAP_RST);
      regs.src_alarm <= SRC_ALM_RST;
      regs.load_alarm <= LOAD_ALM_RST;
    end else if (wr_evt) begin
      case (wr_req.index)
        OFS_OUT_CAP: regs.out_cap <= cap_store(wr_req.word);
        OFS_FWD_VOLT: regs.fwd_volt <= keep_field(wr_req.word, VOLT_LSB, VOLT_W);
        OFS_CFG_A: regs.cfg_a <= wr_req.word;
        OFS_CFG_B: regs.cfg_b <= wr_req.word;
        OFS_CFG_C: regs.cfg_c <= wr_req.word;
        OFS_SRC_CAP: regs.src_cap <= cap_store(wr_req.word);
        OFS_SRC_ALARM: regs.src_alarm <= keep_field(wr_req.word, SRC_ALM_LSB, ALM_W);
        OFS_LOAD_ALARM: regs.load_alarm <= keep_field(wr_req.word, LOAD_ALM_LSB, ALM_W);
        default: regs <= regs;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_word <= 16'h0000;
      rd_ack_tgl <= 1'b0;
    end else if (rd_evt) begin
      rd_ack_tgl <= ~rd_ack_tgl;
      case (rd_index)
        OFS_OUT_CAP: rd_word <= regs.out_cap;
        OFS_FWD_VOLT: rd_word <= regs.fwd_volt;
        OFS_CFG_A: rd_word <= regs.cfg_a;
        OFS_STATUS_A: rd_word <= status_word_a;
        OFS_CFG_B: rd_word <= regs.cfg_b;
        OFS_CFG_C: rd_word <= regs.cfg_c;
        OFS_SRC_CAP: rd_word <= regs.src_cap;
        OFS_SRC_ALARM: rd_word <= regs.src_alarm;
        OFS_LOAD_ALARM: rd_word <= regs.load_alarm;
        default: rd_word <= 16'h0000;
      endcase
    end
  end

  // ****************************************
  // Assertions: link domain
  // ****************************************
  sequence s_ctrl_done;
    byte_done && phase == ph_ctrl;
  endsequence

  sequence s_ack_slot;
    state == st_ack ##1 sda_oe;
  endsequence

  a_nack_low_rail: assert property (@(posedge link_clk) disable iff (link_rst)
    s_ctrl_done and !rail_ok |=> state == st_wait && !sda_oe)
    else $error("acknowledge prepared with both rails low");

  a_own_addr_ack: assert property (@(posedge link_clk) disable iff (link_rst)
    s_ctrl_done and ctrl_match && !start_seen && !stop_seen |=> s_ack_slot)
    else $error("own address not acknowledged");

  a_foreign_addr_nack: assert property (@(posedge link_clk) disable iff (link_rst)
    s_ctrl_done and rx_shift[7:3] != SLAVE_ADDR_FIXED |=> state != st_ack)
    else $error("foreign address acknowledged");

  a_reg_index_ack: assert property (@(posedge link_clk) disable iff (link_rst)
    byte_done && phase == ph_reg && !start_seen && !stop_seen |=> state == st_ack && rd_index == $past(rx_shift))
    else $error("register index not taken or not acknowledged");

  a_sda_change_low: assert property (@(posedge link_clk) disable iff (link_rst)
    $changed(sda_oe) && !$past(start_seen, 2) && !$past(stop_seen, 2) |-> !$past(scl_r, 2))
    else $error("sda drive changed while scl high");

  a_low_byte_first: assert property (@(posedge link_clk) disable iff (link_rst)
    state == st_ack && reading && scl_fall && !start_seen && !stop_seen |=> tx_shift == rd_word_link[7:0] && !tx_high)
    else $error("read word did not start with low byte");

  a_third_byte_nack: assert property (@(posedge link_clk) disable iff (link_rst)
    byte_done && phase == ph_done && !start_seen && !stop_seen |=> state == st_wait ##1 !sda_oe)
    else $error("byte beyond a word acknowledged");

  // ****************************************
  // Assertions: system domain
  // ****************************************
  a_cap_clamped: assert property (@(posedge clk) disable iff (reset)
    regs.out_cap[CAP_LSB +: CAP_W] <= CAP_MAX && regs.out_cap[1:0] == 2'h0 && regs.out_cap[15:13] == 3'h0)
    else $error("current cap outside its field or range");

  a_cap_write_clamp: assert property (@(posedge clk) disable iff (reset)
    wr_evt && wr_req.index == OFS_SRC_CAP && wr_req.word[12:2] > CAP_MAX |=> regs.src_cap[12:2] == CAP_MAX)
    else $error("over-range write not clamped");

  a_status_write_kept: assert property (@(posedge clk) disable iff (reset)
    wr_evt && wr_req.index == OFS_STATUS_A |=> $stable(regs))
    else $error("write to status changed stored registers");

  a_word_write_lands: assert property (@(posedge clk) disable iff (reset)
    wr_evt && wr_req.index == OFS_CFG_A |=> regs.cfg_a == $past(wr_req.word))
    else $error("config word write lost");

  a_alarm_field_only: assert property (@(posedge clk) disable iff (reset)
    wr_evt && wr_req.index == OFS_LOAD_ALARM |=> regs.load_alarm == ($past(wr_req.word) & 16'h3F00))
    else $error("load alarm stored bits outside its field");

endmodule : smbus_word_register_slave

//--- inc/smbus_word_pkg.sv
// Constants and carrier types for the word register serial slave
package smbus_word_pkg;

  // ****************************************
  // Address and byte framing
  // ****************************************
  localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h12;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic DIR_READ = 1'b1;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_OUT_CAP = 8'h14;
  localparam logic [7:0] OFS_FWD_VOLT = 8'h15;
  localparam logic [7:0] OFS_CFG_A = 8'h39;
  localparam logic [7:0] OFS_STATUS_A = 8'h3A;
  localparam logic [7:0] OFS_CFG_B = 8'h3C;
  localparam logic [7:0] OFS_CFG_C = 8'h3D;
  localparam logic [7:0] OFS_SRC_CAP = 8'h3F;
  localparam logic [7:0] OFS_SRC_ALARM = 8'h47;
  localparam logic [7:0] OFS_LOAD_ALARM = 8'h48;

  // ****************************************
  // Field layouts
  // ****************************************
  localparam int CAP_LSB = 2;
  localparam int CAP_W = 11;
  localparam logic [10:0] CAP_MAX = 11'h5F0;
  localparam int VOLT_LSB = 3;
  localparam int VOLT_W = 12;
  localparam int SRC_ALM_LSB = 7;
  localparam int LOAD_ALM_LSB = 8;
  localparam int ALM_W = 6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] OUT_CAP_RST = 16'h05DC;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] SRC_ALM_RST = 16'h0C00;
  localparam logic [15:0] LOAD_ALM_RST = 16'h1000;
  localparam logic [11:0] VOLT_CODE_0 = 12'h1A1;
  localparam logic [11:0] VOLT_CODE_1 = 12'h2EE;
  localparam logic [11:0] VOLT_CODE_2 = 12'h3E8;
  localparam logic [11:0] VOLT_CODE_3 = 12'h536;
  localparam logic [11:0] VOLT_CODE_4 = 12'h683;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [15:0] out_cap;
    logic [15:0] fwd_volt;
    logic [15:0] cfg_a;
    logic [15:0] cfg_b;
    logic [15:0] cfg_c;
    logic [15:0] src_cap;
    logic [15:0] src_alarm;
    logic [15:0] load_alarm;
  } regs_s;

  typedef struct packed {
    logic [7:0] index;
    logic [15:0] word;
  } wr_req_s;

endpackage : smbus_word_pkg

//--- testbench/smbus_host_model.sv
// Behavioural bus host that clocks the serial link and moves bytes
`timescale 1ns/1ps
module smbus_host_model (
  // Bus clock and data pull-down
  output logic scl,
  output logic sda_pull,
  // Resolved data line
  input wire logic sda
);
  // Data moves well after the clock falls, so no false START or STOP is seen
  localparam int T_SET = 1000;
  localparam int T_LOW = 3800;
  localparam int T_HIGH = 4000;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // ****************************************
  // Bit level
  // ****************************************
  task automatic pulse(output logic s);
    #T_LOW;
    scl = 1'b1;
    #T_HIGH;
    s = sda;
    scl = 1'b0;
    #T_SET;
  endtask : pulse

  task automatic start();
    sda_pull = 1'b1;
    #T_HIGH;
    scl = 1'b0;
    #T_SET;
  endtask : start

  task automatic rstart();
    sda_pull = 1'b0;
    #T_LOW;
    scl = 1'b1;
    #(T_HIGH + T_SET);
    sda_pull = 1'b1;
    #T_HIGH;
    scl = 1'b0;
    #T_SET;
  endtask : rstart

  task automatic stop();
    sda_pull = 1'b1;
    #T_LOW;
    scl = 1'b1;
    #T_HIGH;
    sda_pull = 1'b0;
    #(T_HIGH + T_SET);
  endtask : stop

  // ****************************************
  // Byte level
  // ****************************************
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_pull = ~b[i];
      pulse(s);
    end
    sda_pull = 1'b0;
    pulse(ack);
  endtask : send_byte

  task automatic recv_byte(input logic ack_it, output logic [7:0] b);
    logic s;
    sda_pull = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    sda_pull = ack_it;
    pulse(s);
    sda_pull = 1'b0;
  endtask : recv_byte
endmodule : smbus_host_model

//--- testbench/tb_top.sv
// Self-checking bench for the word register serial slave
`timescale 1ns/1ps
module tb_top
  import smbus_word_pkg::*;
;
  localparam logic [15:0] SRC_CAP_DEF = 16'h0A28;
  typedef struct {string nm; logic [127:0] v;} note_s;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic scl, sda_pull, sda_o, sda_oe;
  logic slave_sel_pin_a = 1'b0;
  logic slave_sel_pin_b = 1'b0;
  logic [2:0] program_strap_pin = 3'h0;
  logic source_port_voltage = 1'b1;
  logic output_rail_voltage = 1'b1;
  logic [15:0] status_word_a = 16'h0000;
  regs_s regs, mdl;
  wire logic sda_line;
  logic [7:0] dev_addr;
  integer seed = 15472;
  int bad_count = 0;
  int checks = 0;
  note_s exp_q[$];
  logic [127:0] seen_q[$];
  note_s n;
  logic [7:0] idx_list [10] = '{OFS_OUT_CAP, OFS_FWD_VOLT, OFS_CFG_A, OFS_STATUS_A, OFS_CFG_B,
                                OFS_CFG_C, OFS_SRC_CAP, OFS_SRC_ALARM, OFS_LOAD_ALARM, 8'h50};

  // Open drain line with pull-up
  assign sda_line = (sda_oe ? sda_o : 1'b1) & ~sda_pull;
  always #50 clk = ~clk;
  initial begin
    #17;
    forever #62.5 link_clk = ~link_clk;
  end

  smbus_word_register_slave #(.SRC_CAP_RST(SRC_CAP_DEF)) smbus_word_register_slave_i (
    .clk(clk), .reset(reset), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .slave_sel_pin_a(slave_sel_pin_a),
    .slave_sel_pin_b(slave_sel_pin_b), .program_strap_pin(program_strap_pin),
    .source_port_voltage(source_port_voltage), .output_rail_voltage(output_rail_voltage),
    .status_word_a(status_word_a), .regs(regs));
  smbus_host_model smbus_host_model_i (.scl(scl), .sda_pull(sda_pull), .sda(sda_line));

  // ****************************************
  // Expected register model
  // ****************************************
  function automatic logic [15:0] capf(input logic [15:0] w);
    logic [10:0] f;
    f = w[12:2];
    if (f > CAP_MAX)
      f = CAP_MAX;
    return {3'h0, f, 2'h0};
  endfunction : capf

  function automatic logic [11:0] vcode(input logic [2:0] p);
    case (p)
      3'h1: return VOLT_CODE_1;
      3'h2: return VOLT_CODE_2;
      3'h3: return VOLT_CODE_3;
      3'h4: return VOLT_CODE_4;
      default: return VOLT_CODE_0;
    endcase
  endfunction : vcode

  task automatic store(input logic [7:0] idx, input logic [15:0] w);
    case (idx)
      OFS_OUT_CAP: mdl.out_cap = capf(w);
      OFS_SRC_CAP: mdl.src_cap = capf(w);
      OFS_FWD_VOLT: mdl.fwd_volt = w & 16'h7FF8;
      OFS_CFG_A: mdl.cfg_a = w;
      OFS_CFG_B: mdl.cfg_b = w;
      OFS_CFG_C: mdl.cfg_c = w;
      OFS_SRC_ALARM: mdl.src_alarm = w & 16'h1F80;
      OFS_LOAD_ALARM: mdl.load_alarm = w & 16'h3F00;
      default: ;
    endcase
  endtask : store

  function automatic logic [15:0] rd_exp(input logic [7:0] idx);
    case (idx)
      OFS_OUT_CAP: return mdl.out_cap;
      OFS_FWD_VOLT: return mdl.fwd_volt;
      OFS_CFG_A: return mdl.cfg_a;
      OFS_STATUS_A: return status_word_a;
      OFS_CFG_B: return mdl.cfg_b;
      OFS_CFG_C: return mdl.cfg_c;
      OFS_SRC_CAP: return mdl.src_cap;
      OFS_SRC_ALARM: return mdl.src_alarm;
      OFS_LOAD_ALARM: return mdl.load_alarm;
      default: return 16'h0000;
    endcase
  endfunction : rd_exp

  // ****************************************
  // Notes, comparison and verdict
  // ****************************************
  task automatic note(input string nm, input logic [127:0] e, input logic [127:0] s);
    exp_q.push_back('{nm, e});
    seen_q.push_back(s);
  endtask : note

  task automatic check(input string nm, input logic [127:0] s, input logic [127:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  initial begin
    forever begin
      wait (seen_q.size() != 0);
      n = exp_q.pop_front();
      check(n.nm, seen_q.pop_front(), n.v);
    end
  end

  task automatic give_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // ****************************************
  // Transfers
  // ****************************************
  task automatic byte_out(input logic [7:0] b, input logic ok);
    logic a;
    smbus_host_model_i.send_byte(b, a);
    note("ack", 128'(!ok), 128'(a));
  endtask : byte_out

  // Data bytes beyond the second must be refused; a lone low byte is dropped
  task automatic wr_word(input logic [7:0] idx, input logic [15:0] w, input int nb, input logic ok);
    smbus_host_model_i.start();
    byte_out(dev_addr, ok);
    if (ok) begin
      byte_out(idx, 1'b1);
      for (int k = 0; k < nb; k++) begin
        byte_out(k == 2 ? 8'h5A : (k == 1 ? w[15:8] : w[7:0]), k < 2);
      end
      if (nb >= 2)
        store(idx, w);
    end
    smbus_host_model_i.stop();
    repeat (10) @(posedge clk);
    #1;
    note("regs", mdl, regs);
  endtask : wr_word

  task automatic rd_word(input logic [7:0] idx);
    logic [7:0] lo, hi;
    smbus_host_model_i.start();
    byte_out(dev_addr, 1'b1);
    byte_out(idx, 1'b1);
    smbus_host_model_i.rstart();
    byte_out(dev_addr | 8'h01, 1'b1);
    smbus_host_model_i.recv_byte(1'b1, lo);
    smbus_host_model_i.recv_byte(1'b0, hi);
    smbus_host_model_i.stop();
    note("read", 128'(rd_exp(idx)), 128'({hi, lo}));
  endtask : rd_word

  // Straps are flipped after release: the latched address must still answer
  task automatic do_reset(input logic [2:0] i);
    @(posedge clk);
    #1;
    {slave_sel_pin_b, slave_sel_pin_a} = i[1:0];
    program_strap_pin = i;
    reset = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    reset = 1'b0;
    dev_addr = {SLAVE_ADDR_FIXED, i[1:0], 1'b0};
    mdl = '{OUT_CAP_RST, {1'b0, vcode(i), 3'h0}, CFG_RST, CFG_RST, CFG_RST, capf(SRC_CAP_DEF),
            SRC_ALM_RST, LOAD_ALM_RST};
    repeat (10) @(posedge clk);
    #1;
    note("reset regs", mdl, regs);
    {slave_sel_pin_b, slave_sel_pin_a} = ~i[1:0];
    smbus_host_model_i.start();
    byte_out(dev_addr, 1'b1);
    smbus_host_model_i.stop();
  endtask : do_reset

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    for (int i = 0; i < 5; i++) begin
      do_reset(3'(i));
    end
    @(posedge clk);
    #1;
    status_word_a = 16'($random(seed));
    foreach (idx_list[k]) begin
      wr_word(idx_list[k], k[0] ? 16'($random(seed)) : 16'hFFFF, 2, 1'b1);
    end
    rd_word(OFS_OUT_CAP);
    rd_word(OFS_CFG_A);
    rd_word(OFS_STATUS_A);
    rd_word(8'h50);
    dev_addr ^= 8'h04;
    wr_word(OFS_CFG_B, 16'($random(seed)), 2, 1'b0);
    dev_addr ^= 8'h04;
    for (int r = 0; r < 3; r++) begin
      {source_port_voltage, output_rail_voltage} = 2'(r);
      wr_word(OFS_CFG_C, 16'($random(seed)), 2, r != 0);
    end
    wr_word(OFS_CFG_A, 16'($random(seed)), 3, 1'b1);
    wr_word(OFS_CFG_B, 16'($random(seed)), 1, 1'b1);
    #1;
    give_verdict();
  end

  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
endmodule : tb_top
